//--- logic/axil_slave.sv
/*
  AXI4-Lite slave front end with one write and one read outstanding.
  Assumes the register file answers hit and read data combinationally.
*/
`default_nettype none

module axil_slave #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // Write channels
  input  wire logic [ADDR_W-1:0]      awaddr,
  input  wire logic                   awvalid,
  output var  logic                   awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output var  logic                   wready,
  output var  cal_regs_pkg::axi_resp_t bresp,
  output var  logic                   bvalid,
  input  wire logic                   bready,
  // Read channels
  input  wire logic [ADDR_W-1:0]      araddr,
  input  wire logic                   arvalid,
  output var  logic                   arready,
  output var  logic [31:0]            rdata,
  output var  cal_regs_pkg::axi_resp_t rresp,
  output var  logic                   rvalid,
  input  wire logic                   rready,
  // Register file side
  output wire logic                   wr_en,
  output var  logic [ADDR_W-3:0]      wr_idx,
  output var  logic [15:0]            wr_data,
  output var  logic [1:0]             wr_strb,
  input  wire logic                   wr_hit,
  output wire logic [ADDR_W-3:0]      rd_idx,
  input  wire logic [15:0]            rd_data,
  input  wire logic                   rd_hit
);
  import cal_regs_pkg::*;

  logic aw_held;
  logic w_held;
  wire  aw_take      = awvalid && awready;
  wire  w_take       = wvalid && wready;
  wire  ar_take      = arvalid && arready;
  wire  do_write     = aw_held && w_held && !bvalid;
  wire  next_aw_held = aw_take || (aw_held && !do_write);
  wire  next_w_held  = w_take || (w_held && !do_write);
  wire  next_bvalid  = do_write || (bvalid && !bready);
  wire  next_rvalid  = ar_take || (rvalid && !rready);

  assign wr_en  = do_write;
  assign rd_idx = araddr[ADDR_W-1:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h00000000;
      wr_idx  <= '0;
      wr_data <= 16'h0000;
      wr_strb <= 2'h0;
    end
    else if (ce)
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held;
      wready  <= !next_w_held;
      bvalid  <= next_bvalid;
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (aw_take)
        wr_idx <= awaddr[ADDR_W-1:2];
      if (w_take)
      begin
        wr_data <= wdata[15:0];
        wr_strb <= wstrb[1:0];
      end
      // Unmapped address answers SLVERR
      if (do_write)
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_take)
      begin
        rdata <= {16'h0000, rd_data};
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && do_write |=> bvalid && (bresp == (($past(wr_hit)) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write not answered one edge after it was performed");

endmodule

`default_nettype wire

//--- logic/cal_regs_map.svh
/*
  Register indices, reset values, writable masks and field positions
  of the channel-0 calibration and threshold register bank.
  Assumes byte address = 4 * index on the register bus.
*/
`ifndef CAL_REGS_MAP_SVH
`define CAL_REGS_MAP_SVH

`define IDX_THRESH_HI   6'h07
`define IDX_THRESH_LO   6'h08
`define IDX_CHANNEL0_CONFIG     6'h09
`define IDX_OCAL_HI     6'h0A
`define IDX_OCAL_LO     6'h0B
`define IDX_GCAL_HI     6'h0C
`define IDX_GCAL_LO     6'h0D
`define IDX_DET_CTRL    6'h30
`define IDX_DET_STAT    6'h31

`define RST_ZERO        16'h0000
`define RST_GCAL_HI     16'h8000
`define RST_DET_SEL     3'h0

`define MASK_FULL       16'hFFFF
`define MASK_THRESH_LO  16'hFF0F
`define MASK_CHANNEL0_CONFIG    16'hFFC7
`define MASK_LO_BYTE    16'hFF00
`define MASK_DET_CTRL   16'h0007

`define POS_PHASE       6
`define POS_BYPASS      2
`define POS_DET_CLEAR   8
`define POS_DET_RESTART 9
`define POS_DET_FLAG    8

`endif

//--- logic/cal_regs_pkg.sv
/*
  Types shared by the register bank, its bus slave and detector.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package cal_regs_pkg;
  typedef enum logic [1:0] {
    SEL_OWN_PAIR = 2'h0,
    SEL_SHORTED  = 2'h1,
    SEL_TEST_POS = 2'h2,
    SEL_TEST_NEG = 2'h3
  } input_sel_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
endpackage

`default_nettype wire

//--- logic/ch0_cal_regs.sv
/*
  Channel-0 calibration, DC-removal and current-detect threshold
  register bank behind an AXI4-Lite slave, with decoded settings
  and a current-detect counter.
  Assumes one clock, synchronous active-low reset, samples on aclk.
*/

// Summary of operation
// [R1] Threshold is upper word plus lower byte
// [R2] Selector zero disables, else coefficient 2^-(code+1)
// [R3] Signed 10-bit phase delay, reset zero
// [R4] Bypass bit removes DC filter on channel 0
// [R5] Two-bit input route: own, short, test
// [R6] Offset correction: upper word, lower byte
// [R7] Gain correction upper resets to 8000h
// [R8] Detect after 1 to 128 exceedances
// [R9] Reserved bits read zero, writes ignored
`default_nettype none
`include "cal_regs_map.svh"

module ch0_cal_regs #(
  parameter int ADDR_W   = 8,
  parameter int SAMPLE_W = 24
) (
  // Clock, reset, enable
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]       awaddr,
  input  wire logic                    awvalid,
  output var  logic                    awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output var  logic                    wready,
  output var  cal_regs_pkg::axi_resp_t bresp,
  output var  logic                    bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]       araddr,
  input  wire logic                    arvalid,
  output var  logic                    arready,
  output var  logic [31:0]             rdata,
  output var  cal_regs_pkg::axi_resp_t rresp,
  output var  logic                    rvalid,
  input  wire logic                    rready,
  // Sample stream for current detect
  input  wire logic                    sample_valid,
  input  wire logic [SAMPLE_W-1:0]     sample_value,
  // Current detect
  output var  logic [SAMPLE_W-1:0]     detect_threshold,
  output var  logic                    current_detected,
  // DC removal
  output var  logic                    dc_removal_enable,
  output var  logic [4:0]              dc_removal_shift,
  output var  logic                    ch0_dc_removal_enable,
  // Channel 0 settings
  output var  logic signed [9:0]       ch0_phase_delay,
  output var  cal_regs_pkg::input_sel_t ch0_input_select,
  output var  logic [3:0]              ch0_route,
  output var  logic [23:0]             ch0_offset_corr,
  output var  logic [23:0]             ch0_gain_corr
);
  import cal_regs_pkg::*;

  localparam int IDX_W = ADDR_W - 2;

  // Byte-lane merge limited to writable bits
  function automatic logic [15:0] wmerge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0]  strb,
    input logic [15:0] mask
  );
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    return ((data & lanes) | (old & ~lanes)) & mask;
  endfunction

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    return idx == IDX_W'(`IDX_THRESH_HI) || idx == IDX_W'(`IDX_THRESH_LO)
        || idx == IDX_W'(`IDX_CHANNEL0_CONFIG)   || idx == IDX_W'(`IDX_OCAL_HI)
        || idx == IDX_W'(`IDX_OCAL_LO)   || idx == IDX_W'(`IDX_GCAL_HI)
        || idx == IDX_W'(`IDX_GCAL_LO)   || idx == IDX_W'(`IDX_DET_CTRL)
        || idx == IDX_W'(`IDX_DET_STAT);
  endfunction

  // Register storage
  logic [15:0] detect_threshold_upper;
  logic [15:0] detect_threshold_low_and_dc_block;
  logic [15:0] channel0_config;
  logic [15:0] channel0_offset_cal_upper;
  logic [15:0] channel0_offset_cal_lower;
  logic [15:0] channel0_gain_cal_upper;
  logic [15:0] channel0_gain_cal_lower;
  logic [2:0]  detect_exceed_count_sel;

  // Bus slave side
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [15:0]      wr_data;
  logic [1:0]       wr_strb;
  logic [IDX_W-1:0] rd_idx;
  logic [15:0]      rd_word;
  logic             det_flag;
  logic [7:0]       det_count;

  axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (mapped(wr_idx)),
    .rd_idx  (rd_idx),
    .rd_data (rd_word),
    .rd_hit  (mapped(rd_idx))
  );

  // Write decode
  wire we_thr_hi = wr_en && wr_idx == IDX_W'(`IDX_THRESH_HI);
  wire we_thr_lo = wr_en && wr_idx == IDX_W'(`IDX_THRESH_LO);
  wire we_cfg    = wr_en && wr_idx == IDX_W'(`IDX_CHANNEL0_CONFIG);
  wire we_ocal_h = wr_en && wr_idx == IDX_W'(`IDX_OCAL_HI);
  wire we_ocal_l = wr_en && wr_idx == IDX_W'(`IDX_OCAL_LO);
  wire we_gcal_h = wr_en && wr_idx == IDX_W'(`IDX_GCAL_HI);
  wire we_gcal_l = wr_en && wr_idx == IDX_W'(`IDX_GCAL_LO);
  wire we_det    = wr_en && wr_idx == IDX_W'(`IDX_DET_CTRL);

  // Detector commands ride the upper lane
  wire det_clear   = we_det && wr_strb[1] && wr_data[`POS_DET_CLEAR];
  wire det_restart = we_det && wr_strb[1] && wr_data[`POS_DET_RESTART];

  // Read decode; reserved and unmapped bits return zero
  assign rd_word =
    (rd_idx == IDX_W'(`IDX_THRESH_HI)) ? detect_threshold_upper :
    (rd_idx == IDX_W'(`IDX_THRESH_LO)) ? detect_threshold_low_and_dc_block :
    (rd_idx == IDX_W'(`IDX_CHANNEL0_CONFIG))   ? channel0_config :
    (rd_idx == IDX_W'(`IDX_OCAL_HI))   ? channel0_offset_cal_upper :
    (rd_idx == IDX_W'(`IDX_OCAL_LO))   ? channel0_offset_cal_lower :
    (rd_idx == IDX_W'(`IDX_GCAL_HI))   ? channel0_gain_cal_upper :
    (rd_idx == IDX_W'(`IDX_GCAL_LO))   ? channel0_gain_cal_lower :
    (rd_idx == IDX_W'(`IDX_DET_CTRL))  ? {13'h0000, detect_exceed_count_sel} :
    (rd_idx == IDX_W'(`IDX_DET_STAT))  ? {7'h00, det_flag, det_count} :
    16'h0000; // [R9]

  // Decoded settings
  wire [1:0]  dc_sel_code = detect_threshold_low_and_dc_block[1:0];
  wire [3:0]  dc_sel      = {detect_threshold_low_and_dc_block[3:2], dc_sel_code};
  wire        dc_on       = dc_sel != 4'h0;
  wire        ch0_bypass  = channel0_config[`POS_BYPASS];
  wire [23:0] thr_word    = {detect_threshold_upper, detect_threshold_low_and_dc_block[15:8]};

  // Register file
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      detect_threshold_upper            <= `RST_ZERO;
      detect_threshold_low_and_dc_block <= `RST_ZERO;
      channel0_config                   <= `RST_ZERO;
      channel0_offset_cal_upper         <= `RST_ZERO;
      channel0_offset_cal_lower         <= `RST_ZERO;
      channel0_gain_cal_upper           <= `RST_GCAL_HI; // [R7]
      channel0_gain_cal_lower           <= `RST_ZERO;
      detect_exceed_count_sel           <= `RST_DET_SEL;
    end
    else if (ce)
    begin
      if (we_thr_hi) // [R1]
        detect_threshold_upper <= wmerge(detect_threshold_upper, wr_data, wr_strb, `MASK_FULL);

      if (we_thr_lo) // [R1] [R9]
        detect_threshold_low_and_dc_block <= wmerge(detect_threshold_low_and_dc_block,
                                                    wr_data, wr_strb, `MASK_THRESH_LO);

      if (we_cfg) // [R9]
        channel0_config <= wmerge(channel0_config, wr_data, wr_strb, `MASK_CHANNEL0_CONFIG);

      if (we_ocal_h) // [R6]
        channel0_offset_cal_upper <= wmerge(channel0_offset_cal_upper, wr_data, wr_strb,
                                            `MASK_FULL);

      if (we_ocal_l) // [R6] [R9]
        channel0_offset_cal_lower <= wmerge(channel0_offset_cal_lower, wr_data, wr_strb,
                                            `MASK_LO_BYTE);

      if (we_gcal_h) // [R7]
        channel0_gain_cal_upper <= wmerge(channel0_gain_cal_upper, wr_data, wr_strb,
                                          `MASK_FULL);

      if (we_gcal_l) // [R7] [R9]
        channel0_gain_cal_lower <= wmerge(channel0_gain_cal_lower, wr_data, wr_strb,
                                          `MASK_LO_BYTE);

      if (we_det && wr_strb[0]) // [R8]
        detect_exceed_count_sel <= wr_data[2:0];
    end
  end

  // Settings outputs, one edge behind the registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      detect_threshold      <= '0;
      dc_removal_enable     <= 1'b0;
      dc_removal_shift      <= 5'h00;
      ch0_dc_removal_enable <= 1'b0;
      ch0_phase_delay       <= 10'sh000;
      ch0_input_select      <= SEL_OWN_PAIR;
      ch0_route             <= 4'h1;
      ch0_offset_corr       <= 24'h000000;
      ch0_gain_corr         <= 24'h800000;
    end
    else if (ce)
    begin
      detect_threshold      <= SAMPLE_W'(thr_word); // [R1]
      // Code n selects coefficient 2^-(n+1)
      dc_removal_enable     <= dc_on; // [R2]
      dc_removal_shift      <= dc_on ? {1'b0, dc_sel} + 5'h01 : 5'h00; // [R2]
      ch0_dc_removal_enable <= dc_on && !ch0_bypass; // [R4]
      ch0_phase_delay       <= signed'(channel0_config[15:`POS_PHASE]); // [R3]
      ch0_input_select      <= input_sel_t'(channel0_config[1:0]); // [R5]
      // One-hot route follows the selector
      ch0_route             <= 4'h1 << channel0_config[1:0]; // [R5]
      ch0_offset_corr       <= {channel0_offset_cal_upper,
                                channel0_offset_cal_lower[15:8]}; // [R6]
      ch0_gain_corr         <= {channel0_gain_cal_upper, channel0_gain_cal_lower[15:8]}; // [R7]
    end
  end

  current_detector #(
    .SAMPLE_W (SAMPLE_W)
  ) u_detect (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .sample_valid (sample_valid),
    .sample_value (sample_value),
    .threshold    (detect_threshold),
    .count_sel    (detect_exceed_count_sel),
    .restart      (det_restart),
    .clear        (det_clear),
    .detected     (det_flag),
    .exceed_count (det_count)
  );

  assign current_detected = det_flag;

  threshold_word_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    ce |=> detect_threshold == {$past(detect_threshold_upper),
                                $past(detect_threshold_low_and_dc_block[15:8])})
    else $error("threshold output does not match upper word and lower byte");

  dc_coefficient_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    ce && dc_sel != 4'h0 |=> dc_removal_enable
                             && dc_removal_shift == {1'b0, $past(dc_sel)} + 5'h01)
    else $error("nonzero selector gave wrong coefficient");

  dc_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    ce && dc_sel == 4'h0 |=> !dc_removal_enable && !ch0_dc_removal_enable)
    else $error("zero selector left dc removal on");

  phase_delay_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    ce |=> ch0_phase_delay == $signed($past(channel0_config[15:6])))
    else $error("phase delay output differs from config field");

  ch0_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    ce |=> ch0_dc_removal_enable == ($past(dc_on) && !$past(ch0_bypass)))
    else $error("channel 0 dc removal ignores bypass or global setting");

  input_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    ce |=> ch0_route == (4'h1 << $past(channel0_config[1:0]))
           && ch0_input_select == $past(channel0_config[1:0]))
    else $error("input route does not follow selector");

  offset_word_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    ce && we_ocal_h && wr_strb == 2'h3 ##1 ce |=> ch0_offset_corr[23:8] == $past(wr_data, 2))
    else $error("offset upper word not applied");

  gain_word_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    ce |=> ch0_gain_corr == {$past(channel0_gain_cal_upper), $past(channel0_gain_cal_lower[15:8])})
    else $error("gain correction not assembled from both words");

  gain_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    $rose(aresetn) |-> channel0_gain_cal_upper == 16'h8000 && channel0_gain_cal_lower == 16'h0000)
    else $error("gain upper word did not reset to 8000h");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    ce && we_cfg |=> channel0_config[5:3] == 3'h0 && channel0_offset_cal_lower[7:0] == 8'h00
                     && detect_threshold_low_and_dc_block[7:4] == 4'h0)
    else $error("reserved bits took a written value");

  reserved_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    channel0_config[5:3] == 3'h0 && channel0_gain_cal_lower[7:0] == 8'h00
    && detect_threshold_low_and_dc_block[7:4] == 4'h0)
    else $error("reserved bits hold a nonzero value");

  unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    !mapped(rd_idx) |-> rd_word == 16'h0000)
    else $error("unmapped index read back nonzero");

  offset_byte_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    ce |=> ch0_offset_corr == {$past(channel0_offset_cal_upper),
                               $past(channel0_offset_cal_lower[15:8])})
    else $error("offset correction not assembled from both words");

  thresh_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    ce && we_thr_hi && wr_strb == 2'h3 |=> detect_threshold_upper == $past(wr_data))
    else $error("threshold upper word write did not land");

  detect_restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    ce && det_restart |=> det_count == 8'h00)
    else $error("restart did not zero the exceedance count");

  freeze_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ce |=> $stable(channel0_config) && $stable(ch0_gain_corr) && $stable(det_count))
    else $error("state moved while clock enable was low");

endmodule

`default_nettype wire

//--- logic/current_detector.sv
/*
  Current-detect exceedance counter with sticky detection flag.
  Assumes samples arrive on the same clock as one-cycle strobes.
*/
`default_nettype none

module current_detector #(
  parameter int SAMPLE_W = 24
) (
  // Clock, reset, enable
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // Sample stream
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_value,
  // Settings and commands
  input  wire logic [SAMPLE_W-1:0] threshold,
  input  wire logic [2:0]          count_sel,
  input  wire logic                restart,
  input  wire logic                clear,
  // State
  output var  logic                detected,
  output var  logic [7:0]          exceed_count
);
  import cal_regs_pkg::*;

  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] v);
    return v[SAMPLE_W-1] ? (~v + 1'b1) : v;
  endfunction

  wire logic [7:0] target     = 8'h01 << count_sel;
  wire logic       hit        = sample_valid && (magnitude(sample_value) > threshold);
  wire logic [7:0] next_count = restart ? 8'h00 :
                                (hit && exceed_count != 8'hFF) ? exceed_count + 8'h01 :
                                exceed_count;
  wire logic       set_flag   = hit && !restart && (next_count >= target);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exceed_count <= 8'h00;
      detected     <= 1'b0;
    end
    else if (ce)
    begin
      exceed_count <= next_count;
      // Set wins over a simultaneous clear
      detected     <= set_flag || (detected && !clear); // [R8]
    end
  end

  detect_fires_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    ce && hit && !restart && (exceed_count + 8'h01 == target) |=> detected)
    else $error("detection missed at the programmed exceedance count");

  detect_early_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    ce && !detected && (next_count < target) |=> !detected)
    else $error("detection raised before the programmed count");

endmodule

`default_nettype wire

//--- verification/ch0_cal_regs_tb.sv
/*
  Self-checking bench for the channel-0 calibration register bank.
  Assumes the bank package and register map header compile first.
*/
`default_nettype none

module ch0_cal_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cal_regs_pkg::*;

  logic              aclk = 1'h0;
  logic              aresetn = 1'h0;
  logic              ce = 1'h1;
  logic [7:0]        awaddr = 8'h0;
  logic [7:0]        araddr = 8'h0;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'h0;
  logic              awvalid = 1'h0;
  logic              wvalid = 1'h0;
  logic              bready = 1'h0;
  logic              arvalid = 1'h0;
  logic              rready = 1'h0;
  logic              sample_valid = 1'h0;
  logic [23:0]       sample_value = 24'h0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       rdata;
  axi_resp_t         bresp, rresp;
  logic [23:0]       detect_threshold, ch0_offset_corr, ch0_gain_corr;
  logic              current_detected, dc_removal_enable, ch0_dc_removal_enable;
  logic [4:0]        dc_removal_shift;
  logic signed [9:0] ch0_phase_delay;
  input_sel_t        ch0_input_select;
  logic [3:0]        ch0_route;
  int                n_mismatch = 0;
  int                checks = 0;

  ch0_cal_regs dut (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .sample_valid, .sample_value, .detect_threshold,
    .current_detected, .dc_removal_enable, .dc_removal_shift,
    .ch0_dc_removal_enable, .ch0_phase_delay, .ch0_input_select, .ch0_route,
    .ch0_offset_corr, .ch0_gain_corr
  );

  always #25 aclk = ~aclk;

  task automatic final_report();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input axi_resp_t got, input axi_resp_t exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One edge of a bounded wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 2000)
    begin
      n_mismatch++;
      $display("wrong value at %0t: bus wait timed out", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] st,
                    input axi_resp_t er);
    int   n;
    logic a, w;
    n = 0;
    a = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    awvalid <= 1'h1;
    wdata   <= {16'h0, d};
    wstrb   <= {2'h0, st};
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(a && w))
    begin
      tick(n);
      a = a | awready;
      w = w | wready;
      if (a) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    do tick(n); while (!bvalid);
    bready <= 1'h0;
    chk_resp(bresp, er, "write resp");
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] ed, input axi_resp_t er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do tick(n); while (!arready);
    arvalid <= 1'h0;
    do tick(n); while (!rvalid);
    rready <= 1'h0;
    chk(rdata, {16'h0, ed}, "read data");
    chk_resp(rresp, er, "read resp");
  endtask

  // Decoded outputs lag the registers by one edge
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic sample(input logic [23:0] v);
    @(posedge aclk);
    sample_valid <= 1'h1;
    sample_value <= v;
    @(posedge aclk);
    sample_valid <= 1'h0;
  endtask

  task automatic t_reset();
    logic [15:0] tab [7];
    tab = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
    for (int i = 0; i < 7; i++)
      rd(6'h07 + 6'(i), tab[i], RESP_OKAY);
    chk(32'(ch0_gain_corr), 32'h800000, "gain rst");
    chk(32'(ch0_offset_corr), 32'h0, "offset rst");
    chk(32'(detect_threshold), 32'h0, "thr rst");
    chk({22'h0, ch0_phase_delay}, 32'h0, "phase rst");
    chk(32'(ch0_route), 32'h1, "route rst");
  endtask

  task automatic t_thresh();
    wr(6'h07, 16'hABCD, 2'h3, RESP_OKAY);
    wr(6'h08, 16'hFFFF, 2'h3, RESP_OKAY);
    wr(6'h07, 16'h1111, 2'h1, RESP_OKAY);
    rd(6'h07, 16'hAB11, RESP_OKAY);
    rd(6'h08, 16'hFF0F, RESP_OKAY);
    settle();
    chk(32'(detect_threshold), 32'hAB11FF, "threshold");
  endtask

  task automatic t_dc();
    for (int c = 0; c < 16; c++)
    begin
      wr(6'h08, 16'(c), 2'h1, RESP_OKAY);
      settle();
      chk(32'(dc_removal_enable), 32'(c != 0), "dc on");
      chk(32'(dc_removal_shift), 32'(c ? c + 1 : 0), "dc shift");
      chk(32'(ch0_dc_removal_enable), 32'(c != 0), "ch0 dc on");
    end
  endtask

  task automatic t_cfg();
    wr(6'h09, 16'hFFFF, 2'h3, RESP_OKAY);
    rd(6'h09, 16'hFFC7, RESP_OKAY);
    settle();
    chk(32'(ch0_dc_removal_enable), 32'h0, "bypass");
    chk(32'(dc_removal_enable), 32'h1, "global dc");
    chk({22'h0, ch0_phase_delay}, 32'h3FF, "phase");
    for (int m = 0; m < 4; m++)
    begin
      wr(6'h09, 16'h8000 | 16'(m), 2'h3, RESP_OKAY);
      settle();
      chk(32'(ch0_input_select), 32'(m), "mux");
      chk(32'(ch0_route), 32'(1 << m), "route");
      chk({22'h0, ch0_phase_delay}, 32'h200, "phase");
      chk(32'(ch0_dc_removal_enable), 32'h1, "no bypass");
    end
  endtask

  task automatic t_cal();
    wr(6'h0A, 16'h1234, 2'h3, RESP_OKAY);
    wr(6'h0B, 16'h56FF, 2'h3, RESP_OKAY);
    wr(6'h0C, 16'h9ABC, 2'h3, RESP_OKAY);
    wr(6'h0D, 16'hDE77, 2'h3, RESP_OKAY);
    rd(6'h0B, 16'h5600, RESP_OKAY);
    rd(6'h0D, 16'hDE00, RESP_OKAY);
    settle();
    chk(32'(ch0_offset_corr), 32'h123456, "offset");
    chk(32'(ch0_gain_corr), 32'h9ABCDE, "gain");
  endtask

  task automatic t_unmapped();
    wr(6'h20, 16'hFFFF, 2'h3, RESP_SLVERR);
    rd(6'h20, 16'h0, RESP_SLVERR);
  endtask

  // Threshold is 000100h here; equal magnitude must not count
  task automatic t_det(input int sel);
    wr(6'h30, 16'h0300 | 16'(sel), 2'h3, RESP_OKAY);
    settle();
    chk(32'(current_detected), 32'h0, "cleared");
    for (int i = 1; i < (1 << sel); i++)
      sample(24'h000101);
    sample(24'h000100);
    settle();
    chk(32'(current_detected), 32'h0, "early");
    sample(24'hFFFEFF);
    settle();
    chk(32'(current_detected), 32'h1, "detected");
    rd(6'h31, 16'h0100 | 16'(1 << sel), RESP_OKAY);
  endtask

  // A hit while enable is low must not count
  task automatic t_freeze();
    @(posedge aclk);
    ce <= 1'h0;
    sample(24'hFFFEFF);
    @(posedge aclk);
    ce <= 1'h1;
    rd(6'h31, 16'h0180, RESP_OKAY);
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_thresh();
    t_dc();
    t_cfg();
    t_cal();
    t_unmapped();
    wr(6'h07, 16'h0001, 2'h3, RESP_OKAY);
    wr(6'h08, 16'h0000, 2'h2, RESP_OKAY);
    t_det(0);
    t_det(2);
    t_det(7);
    t_freeze();
    final_report();
  end
endmodule

`default_nettype wire
